// [logic/xscs_pkg.sv]
// package: port indices, bit positions, reset values and state codes of the control/status ports
`default_nettype none
package xscs_pkg;
   // i/o indices of the two ports
   localparam logic [7:0] CTRL_PORT_IDX = 8'h61;
   localparam logic [7:0] STATUS_PORT_IDX = 8'h62;

   // control port field positions
   localparam int CTRL_KBD_CLEAR_BIT = 7;
   localparam int CTRL_KBD_CLOCK_ENABLE_BIT = 6;
   localparam int CTRL_IO_CHECK_DISABLE_BIT = 5;
   localparam int CTRL_RAM_CHECK_DISABLE_BIT = 4;
   localparam int CTRL_SWITCH_BANK_BIT = 3;
   localparam int CTRL_SPARE_BIT = 2;
   localparam int CTRL_SPEAKER_ENABLE_BIT = 1;
   localparam int CTRL_TIMER2_GATE_BIT = 0;

   // control port reset value
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // status port field positions
   localparam int STAT_RAM_CHECK_BIT = 7;
   localparam int STAT_IO_CHECK_BIT = 6;
   localparam int STAT_TIMER2_OUT_BIT = 5;
   localparam int STAT_SPEAKER_INV_BIT = 4;
   localparam int STAT_SWITCH_MSB = 3;
   localparam int STAT_SWITCH_LSB = 0;

   // fixed parity status: no errors ever reported
   localparam logic STAT_RAM_CHECK_VALUE = 1'b0;
   localparam logic STAT_IO_CHECK_VALUE = 1'b0;

   // hardwired low switch bank: size high, size low, coprocessor, loop on self test
   localparam logic [3:0] SWITCH_LOW_BANK = 4'hF;

   // reset values of the speaker pin and keyboard interrupt flops and the read data flop
   localparam logic SPEAKER_PIN_RESET = 1'b0;
   localparam logic KBD_IRQ_RESET = 1'b0;
   localparam logic [7:0] RDATA_RESET = 8'h00;

   // keyboard clock toggle tracking for the nmi request
   typedef enum logic [1:0] {
      XSCS_NMI_IDLE = 2'b01,
      XSCS_NMI_ARMED = 2'b10
   } xscs_nmi_state_t;
endpackage
`default_nettype wire

// [logic/xscs_ports.sv]
// module: system control port and system status port on the processor i/o bus
`default_nettype none
module xscs_ports #(
   parameter int ADDR_W = 8,
   parameter logic [3:0] LOW_BANK = xscs_pkg::SWITCH_LOW_BANK
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // processor i/o bus
   input wire logic [ADDR_W-1:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_rd_ack,
   // keyboard side
   input wire logic kbd_scan_mode,
   input wire logic kbd_irq_raw,
   input wire logic [3:0] kbd_mode_switches,
   output logic kbd_clear,
   output logic keyboard_interrupt_line,
   output logic kbd_clock_o,
   output logic kbd_clock_oe,
   output logic nmi_request,
   // parity check controls
   output logic io_channel_check_disable,
   output logic ram_check_disable,
   // timer and speaker
   input wire logic timer2_output,
   output logic timer2_gate,
   output logic speaker_output_enable,
   output logic speaker_pin
);
   // exact index match, used for both ports; only the control port decodes writes
   function automatic logic idx_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
      idx_hit = (addr == ADDR_W'(idx));
   endfunction

   // registers
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic rd_ack_reg;
   logic rd_ack_next;
   logic speaker_pin_reg;
   logic speaker_pin_next;
   logic kbd_irq_reg;
   logic kbd_irq_next;
   logic clock_oe_reg;
   logic clock_oe_next;
   logic nmi_reg;
   logic nmi_next;
   xscs_pkg::xscs_nmi_state_t nmi_state_reg;
   xscs_pkg::xscs_nmi_state_t nmi_state_next;

   // address decode of the two ports
   wire logic ctrl_wr;
   wire logic ctrl_rd;
   wire logic stat_rd;
   wire logic any_rd;
   assign ctrl_wr = io_wr & idx_hit(io_addr, xscs_pkg::CTRL_PORT_IDX);
   assign ctrl_rd = io_rd & idx_hit(io_addr, xscs_pkg::CTRL_PORT_IDX);
   assign stat_rd = io_rd & idx_hit(io_addr, xscs_pkg::STATUS_PORT_IDX);
   assign any_rd = ctrl_rd | stat_rd;

   // a write at the status index has no decode, so it is dropped
   // without touching any state of this block

   // written control byte fields
   wire logic wr_clock_enable;
   assign wr_clock_enable = io_wdata[xscs_pkg::CTRL_KBD_CLOCK_ENABLE_BIT];

   // whole byte is stored, spare bit included, so readback is exact
   assign ctrl_next = ctrl_wr ? io_wdata : ctrl_reg;

   // control fields taken from the next value so that pin effects
   // line up with the register update on the same edge
   wire logic next_kbd_clear;
   wire logic next_clock_enable;
   wire logic next_speaker_enable;
   assign next_kbd_clear = ctrl_next[xscs_pkg::CTRL_KBD_CLEAR_BIT];
   assign next_clock_enable = ctrl_next[xscs_pkg::CTRL_KBD_CLOCK_ENABLE_BIT];
   assign next_speaker_enable = ctrl_next[xscs_pkg::CTRL_SPEAKER_ENABLE_BIT];

   // keyboard interrupt is blocked while clear is held, so a key
   // arriving during the clear cannot leak through
   assign kbd_irq_next = kbd_irq_raw & ~next_kbd_clear;

   // open-drain keyboard clock: pulled low whenever the enable is off
   assign clock_oe_next = ~next_clock_enable;

   // speaker pin follows the timer output only while enabled
   assign speaker_pin_next = timer2_output & next_speaker_enable;

   // status byte composer shares the live sources
   xscs_stat_if st_if ();
   assign st_if.switch_bank_select = ctrl_reg[xscs_pkg::CTRL_SWITCH_BANK_BIT];
   assign st_if.speaker_pin = speaker_pin_reg;
   assign st_if.timer2_output = timer2_output;
   assign st_if.high_switches = kbd_mode_switches;

   xscs_status_compose #(
      .LOW_BANK(LOW_BANK)
   ) u_compose (
      .st(st_if.composer)
   );

   // read data: control readback or status byte, zero elsewhere
   // an unmapped read gets no ack so another decoder may claim it
   assign rdata_next = ctrl_rd ? ctrl_reg :
                       stat_rd ? st_if.status_byte :
                       xscs_pkg::RDATA_RESET;
   assign rd_ack_next = any_rd;

   // nmi sequencer: only meaningful in keyboard scan mode; leaving
   // scan mode drops any pending arm so a stale low write cannot fire
   always_comb begin
      nmi_state_next = nmi_state_reg;
      nmi_next = 1'b0;
      unique case (nmi_state_reg)
         xscs_pkg::XSCS_NMI_IDLE: begin
            if (kbd_scan_mode && ctrl_wr && !wr_clock_enable) begin
               nmi_state_next = xscs_pkg::XSCS_NMI_ARMED;
            end
         end
         xscs_pkg::XSCS_NMI_ARMED: begin
            if (!kbd_scan_mode) begin
               nmi_state_next = xscs_pkg::XSCS_NMI_IDLE;
            end else if (ctrl_wr && wr_clock_enable) begin
               nmi_next = 1'b1;
               nmi_state_next = xscs_pkg::XSCS_NMI_IDLE;
            end
         end
         default: begin
            nmi_state_next = xscs_pkg::XSCS_NMI_IDLE;
         end
      endcase
   end

   // control register; every bit clears on reset
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg <= xscs_pkg::CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // bus answer flops
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_reg <= xscs_pkg::RDATA_RESET;
         rd_ack_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rd_ack_reg <= rd_ack_next;
      end
   end

   // pin-facing flops
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         speaker_pin_reg <= xscs_pkg::SPEAKER_PIN_RESET;
         kbd_irq_reg <= xscs_pkg::KBD_IRQ_RESET;
         clock_oe_reg <= 1'b1;
      end else begin
         speaker_pin_reg <= speaker_pin_next;
         kbd_irq_reg <= kbd_irq_next;
         clock_oe_reg <= clock_oe_next;
      end
   end

   // nmi tracking flops
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         nmi_state_reg <= xscs_pkg::XSCS_NMI_IDLE;
         nmi_reg <= 1'b0;
      end else begin
         nmi_state_reg <= nmi_state_next;
         nmi_reg <= nmi_next;
      end
   end

   // bus outputs
   assign io_rdata = rdata_reg;
   assign io_rd_ack = rd_ack_reg;

   // keyboard outputs; the code port owner clears itself on kbd_clear,
   // and firmware refills it after a scan
   assign kbd_clear = ctrl_reg[xscs_pkg::CTRL_KBD_CLEAR_BIT];
   assign keyboard_interrupt_line = kbd_irq_reg;
   assign kbd_clock_o = 1'b0; // open drain only ever pulls low
   assign kbd_clock_oe = clock_oe_reg;
   assign nmi_request = nmi_reg;

   // parity check disables go to the checkers outside
   assign io_channel_check_disable = ctrl_reg[xscs_pkg::CTRL_IO_CHECK_DISABLE_BIT];
   assign ram_check_disable = ctrl_reg[xscs_pkg::CTRL_RAM_CHECK_DISABLE_BIT];

   // timer gate and speaker
   assign timer2_gate = ctrl_reg[xscs_pkg::CTRL_TIMER2_GATE_BIT];
   assign speaker_output_enable = ctrl_reg[xscs_pkg::CTRL_SPEAKER_ENABLE_BIT];
   assign speaker_pin = speaker_pin_reg;
endmodule
`default_nettype wire

// [logic/xscs_stat_if.sv]
// interface: signals between the port logic and the status byte composer
`default_nettype none
interface xscs_stat_if;
   logic switch_bank_select;
   logic speaker_pin;
   logic timer2_output;
   logic [3:0] high_switches;
   logic [7:0] status_byte;

   // port logic supplies the sources and reads the composed byte
   modport ports (
      output switch_bank_select,
      output speaker_pin,
      output timer2_output,
      output high_switches,
      input status_byte
   );

   // composer turns sources into the status byte
   modport composer (
      input switch_bank_select,
      input speaker_pin,
      input timer2_output,
      input high_switches,
      output status_byte
   );
endinterface
`default_nettype wire

// [logic/xscs_status_compose.sv]
// module: builds the read-only system status byte from live sources
`default_nettype none
module xscs_status_compose #(
   parameter logic [3:0] LOW_BANK = xscs_pkg::SWITCH_LOW_BANK
) (
   // sources and composed byte
   xscs_stat_if.composer st
);
   // switch nibble: hardwired bank or the keyboard mode settings
   wire logic [3:0] switch_nibble;
   assign switch_nibble = st.switch_bank_select ? st.high_switches : LOW_BANK;

   // parity flags are forced low since no parity checker exists here
   assign st.status_byte[xscs_pkg::STAT_RAM_CHECK_BIT] = xscs_pkg::STAT_RAM_CHECK_VALUE;
   assign st.status_byte[xscs_pkg::STAT_IO_CHECK_BIT] = xscs_pkg::STAT_IO_CHECK_VALUE;

   // live timer output, unregistered so a poll sees the current level
   assign st.status_byte[xscs_pkg::STAT_TIMER2_OUT_BIT] = st.timer2_output;

   // inverted speaker pin: 0 means speaker on
   assign st.status_byte[xscs_pkg::STAT_SPEAKER_INV_BIT] = ~st.speaker_pin;

   // low nibble from the selected switch bank
   assign st.status_byte[xscs_pkg::STAT_SWITCH_MSB:xscs_pkg::STAT_SWITCH_LSB] = switch_nibble;
endmodule
`default_nettype wire

// [verification/testbench.sv]
// testbench: random control writes, status reads and the scan-mode nmi toggle
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, sys_rst, io_wr, io_rd, kbd_scan_mode, kbd_irq_raw, timer2_output;
   logic [7:0] io_addr, io_wdata, io_rdata, d, s;
   logic [3:0] kbd_mode_switches;
   logic io_rd_ack, kbd_clear, keyboard_interrupt_line, kbd_clock_o, kbd_clock_oe;
   logic nmi_request, io_chk_dis, ram_chk_dis, timer2_gate, spk_en, speaker_pin;
   logic [7:0] exp_q[$];
   int num_errors = 0;
   int checks_done = 0;
   xscs_ports xscs_ports_i (.core_clk(core_clk), .sys_rst(sys_rst), .io_addr(io_addr),
      .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .io_rd_ack(io_rd_ack), .kbd_scan_mode(kbd_scan_mode), .kbd_irq_raw(kbd_irq_raw),
      .kbd_mode_switches(kbd_mode_switches), .kbd_clear(kbd_clear),
      .keyboard_interrupt_line(keyboard_interrupt_line), .kbd_clock_o(kbd_clock_o),
      .kbd_clock_oe(kbd_clock_oe), .nmi_request(nmi_request),
      .io_channel_check_disable(io_chk_dis), .ram_check_disable(ram_chk_dis),
      .timer2_output(timer2_output), .timer2_gate(timer2_gate),
      .speaker_output_enable(spk_en), .speaker_pin(speaker_pin));
   // 125 mhz clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   // one-cycle strobes; wr returns once the write has landed on the pins
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      io_wr <= 1'b1;
      io_addr <= a;
      io_wdata <= v;
      @(posedge core_clk);
      io_wr <= 1'b0;
      @(negedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input bit hit);
      if (hit) exp_q.push_back(e);
      @(posedge core_clk);
      io_rd <= 1'b1;
      io_addr <= a;
      @(posedge core_clk);
      io_rd <= 1'b0;
   endtask
   // status byte expected from the live inputs and the control value
   function automatic logic [7:0] sts(input logic [7:0] c);
      return {2'b00, timer2_output, ~(timer2_output & c[1]),
         c[3] ? kbd_mode_switches : xscs_pkg::SWITCH_LOW_BANK};
   endfunction
   // answer watcher: an ack with nothing pending is itself a mismatch
   always @(posedge core_clk) begin
      if (io_rd_ack === 1'b1) begin
         if (exp_q.size() == 0) chk("stray ack", 8'h00, 8'h01);
         else chk("read data", exp_q.pop_front(), io_rdata);
      end
   end
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      {sys_rst, io_wr, io_rd, kbd_scan_mode, kbd_irq_raw, timer2_output} = 6'b100000;
      io_addr = 8'h00;
      io_wdata = 8'h00;
      kbd_mode_switches = 4'h0;
      void'($urandom(89824));
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(negedge core_clk);
      chk("oe after reset", 8'h01, kbd_clock_oe);
      rd(8'h61, 8'h00, 1'b1);
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         d = 8'($urandom);
         d[3] = i[0];
         @(posedge core_clk);
         timer2_output <= 1'($urandom);
         kbd_irq_raw <= 1'($urandom);
         kbd_mode_switches <= 4'($urandom);
         wr(8'h61, d);
         chk("ctrl pins", d & 8'hF3, {kbd_clear, ~kbd_clock_oe, io_chk_dis, ram_chk_dis,
            2'b00, spk_en, timer2_gate});
         chk("irq line", kbd_irq_raw & ~d[7], keyboard_interrupt_line);
         chk("speaker pin", timer2_output & d[1], speaker_pin);
         chk("clock drive", 8'h00, kbd_clock_o);
         s = sts(d);
         rd(8'h61, d, 1'b1);
         rd(8'h62, s, 1'b1);
         wr(8'h62, ~s);
         rd(8'h62, s, 1'b1);
         rd(8'h63, 8'h00, 1'b0);
      end
      $display("test control and status done");
      for (int m = 1; m >= 0; m--) begin
         @(posedge core_clk);
         kbd_scan_mode <= 1'(m);
         wr(8'h61, 8'h00);
         chk("nmi on arm", 8'h00, nmi_request);
         wr(8'h61, 8'h40);
         chk("nmi on toggle", 8'(m), nmi_request);
         // firmware answers the nmi by refilling the code port, which lies outside this block
         wr(8'h60, 8'($urandom));
         rd(8'h61, 8'h40, 1'b1);
         wr(8'h61, 8'h40);
         chk("nmi repeat", 8'h00, nmi_request);
      end
      $display("test nmi done");
      for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(posedge core_clk);
      if (exp_q.size() > 0) chk("pending reads", 8'h00, 8'(exp_q.size()));
      close_out();
   end
endmodule
`default_nettype wire

// [verification/xscs_ports_asserts.sv]
// checker: timing and value relations on the control/status port pins
`default_nettype none
module xscs_ports_asserts #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // i/o bus
   input wire logic [ADDR_W-1:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_rd_ack,
   // keyboard and pins
   input wire logic kbd_scan_mode,
   input wire logic kbd_irq_raw,
   input wire logic kbd_clear,
   input wire logic keyboard_interrupt_line,
   input wire logic kbd_clock_oe,
   input wire logic nmi_request,
   input wire logic timer2_output,
   input wire logic speaker_output_enable,
   input wire logic speaker_pin
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // address decode of the two ports
   wire logic ctrl_hit = io_addr == ADDR_W'(xscs_pkg::CTRL_PORT_IDX);
   wire logic stat_hit = io_addr == ADDR_W'(xscs_pkg::STATUS_PORT_IDX);
   wire logic rd_hit = io_rd && (ctrl_hit || stat_hit);
   // scan-mode keyboard clock toggle steps
   sequence s_arm; io_wr && ctrl_hit && !io_wdata[6] && kbd_scan_mode; endsequence
   sequence s_fire; io_wr && ctrl_hit && io_wdata[6] && kbd_scan_mode; endsequence
   // the gap cycle must neither leave scan mode nor carry its own control write
   sequence s_gap; kbd_scan_mode && !(io_wr && ctrl_hit); endsequence
   sequence s_stat_rd; io_rd && stat_hit; endsequence
   a_read_ack_next: assert property (rd_hit |=> io_rd_ack) else $error("no read ack");
   a_idle_bus_quiet: assert property (
      !rd_hit |=> !io_rd_ack && io_rdata == 8'h00)
      else $error("stray read answer");
   a_status_fixed: assert property (
      s_stat_rd |=> io_rdata[7:6] == 2'b00
      && io_rdata[5] == $past(timer2_output) && io_rdata[4] == !$past(speaker_pin))
      else $error("status byte upper bits wrong");
   a_clock_hold_low: assert property (
      io_wr && ctrl_hit |=> kbd_clock_oe == !$past(io_wdata[6]))
      else $error("keyboard clock drive wrong");
   a_irq_gated: assert property (
      !$past(sys_rst) |-> keyboard_interrupt_line == ($past(kbd_irq_raw) && !kbd_clear))
      else $error("keyboard interrupt not gated");
   a_speaker_follow: assert property (
      speaker_pin == ($past(timer2_output) && speaker_output_enable))
      else $error("speaker pin wrong");
   a_nmi_toggle: assert property (
      s_arm ##1 s_gap ##1 s_fire |=> nmi_request)
      else $error("nmi missing");
   a_nmi_pulse: assert property (nmi_request |=> !nmi_request) else $error("nmi too long");
endmodule
bind xscs_ports xscs_ports_asserts #(.ADDR_W(ADDR_W)) xscs_ports_asserts_i (
   .core_clk(core_clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
   .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_ack(io_rd_ack),
   .kbd_scan_mode(kbd_scan_mode), .kbd_irq_raw(kbd_irq_raw), .kbd_clear(kbd_clear),
   .keyboard_interrupt_line(keyboard_interrupt_line), .kbd_clock_oe(kbd_clock_oe),
   .nmi_request(nmi_request), .timer2_output(timer2_output),
   .speaker_output_enable(speaker_output_enable), .speaker_pin(speaker_pin));
`default_nettype wire
